// ### tsc_defines.svh
// constants of the serial temperature sensor front end
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

`define TSC_CLK_KHZ 250000
`define TSC_CONV_MS_8 75
`define TSC_CONV_MS_9 150
`define TSC_CONV_MS_10 300
`define TSC_CONV_MS_11 600
`define TSC_CONV_MS_12 1200

`define TSC_PTR_CFG 2'h0
`define TSC_PTR_TLO 2'h1
`define TSC_PTR_THI 2'h2
`define TSC_PTR_NONE 2'h3

`define TSC_ADDR_DIR_BIT 7
`define TSC_ADDR_PAD_HI 6
`define TSC_ADDR_PAD_LO 2
`define TSC_ADDR_PTR_HI 1
`define TSC_ADDR_PTR_LO 0

`define TSC_CFG_FIXED 3'h7
`define TSC_CFG_SHOT_BIT 4
`define TSC_CFG_RES_HI 3
`define TSC_CFG_RES_LO 1
`define TSC_CFG_SD_BIT 0
`define TSC_RST_SHOT 1'b0
`define TSC_RST_RES 3'h1
`define TSC_RST_SD 1'b1
`define TSC_RES_TOP_BIT 2

`define TSC_BIT_LAST 3'h7
`define TSC_ADC_BITS 12
`define TSC_PAD_BITS 4
`define TSC_TEMP_BITS 16
`define TSC_RES_MIN_BITS 8
`define TSC_RES_MAX_BITS 12

`endif

// ### tsc_pkg.sv
// types of the serial temperature sensor front end
package tsc_pkg;
   typedef logic [2:0] tsc_res_t;
   typedef enum logic {conv_idle, conv_run} tsc_conv_state_t;
   typedef enum logic [1:0] {ser_addr, ser_read, ser_write} tsc_ser_phase_t;
endpackage : tsc_pkg

// ### tsc_conv_if.sv
// link between the register front end and the conversion sequencer
`timescale 1ns/100ps
interface tsc_conv_if;
   import tsc_pkg::*;
   logic shutdown;
   logic shot_req;
   tsc_res_t res;
   logic done;
   logic done_shot;
   tsc_res_t res_used;
   modport ctrl (output shutdown, output shot_req, output res, input done, input done_shot, input res_used);
   modport conv (input shutdown, input shot_req, input res, output done, output done_shot, output res_used);
endinterface : tsc_conv_if

// ### tsc_conv_seq.sv
// conversion sequencer: continuous and single conversions timed by resolution
`timescale 1ns/100ps
`include "tsc_defines.svh"
module tsc_conv_seq import tsc_pkg::*; #(
   parameter int unsigned CYC_8 = 1,
   parameter int unsigned CYC_9 = 1,
   parameter int unsigned CYC_10 = 1,
   parameter int unsigned CYC_11 = 1,
   parameter int unsigned CYC_12 = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   tsc_conv_if.conv conv
);
   if (CYC_8 == 0 || CYC_9 == 0 || CYC_10 == 0 || CYC_11 == 0 || CYC_12 == 0) begin : g_bad
      $error("conversion cycle counts must be at least one");
   end

   tsc_conv_state_t state;
   logic [31:0] cnt;
   logic by_shot;
   tsc_res_t res_used;

   function automatic logic [31:0] cycles_for(input tsc_res_t r);
      logic [31:0] c;
      c = 32'(CYC_12);
      if (!r[`TSC_RES_TOP_BIT]) begin
         case (r[1:0])
            2'h0: c = 32'(CYC_8);
            2'h1: c = 32'(CYC_9);
            2'h2: c = 32'(CYC_10);
            default: c = 32'(CYC_11);
         endcase
      end
      return c - 32'h1;
   endfunction : cycles_for

   assign conv.done = (state == conv_run) && (cnt == 32'h0);
   assign conv.done_shot = conv.done && by_shot;
   assign conv.res_used = res_used;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= conv_idle;
         cnt <= 32'h0;
         by_shot <= 1'b0;
         res_used <= `TSC_RST_RES;
      end else begin
         case (state)
            conv_idle: begin
               if (!conv.shutdown || conv.shot_req) begin
                  state <= conv_run;
                  cnt <= cycles_for(conv.res);
                  by_shot <= conv.shutdown;
                  res_used <= conv.res;
               end
            end
            conv_run: begin
               if (cnt != 32'h0) begin
                  cnt <= cnt - 32'h1;
               end else if (!conv.shutdown) begin
                  // back to back while running continuously
                  cnt <= cycles_for(conv.res);
                  by_shot <= 1'b0;
                  res_used <= conv.res;
               end else begin
                  // shutdown only takes effect after the running result is stored
                  state <= conv_idle;
               end
            end
            default: state <= conv_idle;
         endcase
      end
   end
endmodule : tsc_conv_seq

// ### tsc_serial_config.sv
// serial temperature sensor front end: configuration, temperature bytes, spi / 3-wire slave
`timescale 1ns/100ps
`include "tsc_defines.svh"
module tsc_serial_config import tsc_pkg::*; #(
   parameter int unsigned CONV_CYC_8 = `TSC_CONV_MS_8 * `TSC_CLK_KHZ,
   parameter int unsigned CONV_CYC_9 = `TSC_CONV_MS_9 * `TSC_CLK_KHZ,
   parameter int unsigned CONV_CYC_10 = `TSC_CONV_MS_10 * `TSC_CLK_KHZ,
   parameter int unsigned CONV_CYC_11 = `TSC_CONV_MS_11 * `TSC_CLK_KHZ,
   parameter int unsigned CONV_CYC_12 = `TSC_CONV_MS_12 * `TSC_CLK_KHZ
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_chip_enable,
   input wire logic i_serial_clk,
   input wire logic i_serial_in,
   input wire logic i_interface_select_strap,
   input wire logic [`TSC_ADC_BITS-1:0] i_adc_sample,
   output logic o_serial_out,
   output logic o_serial_out_oe_b
);
   tsc_conv_if conv_link ();

   logic [3:0] sync1;
   logic [3:0] sync2;
   logic ce_q;
   logic sclk_q;
   logic spi_mode;
   logic idle_high;

   logic shot;
   tsc_res_t res;
   logic sd;
   logic [7:0] temp_lo;
   logic [7:0] temp_hi;

   tsc_ser_phase_t phase;
   logic [2:0] bit_cnt;
   logic [1:0] ptr;
   logic [7:0] rx_sr;
   logic [7:0] tx_sr;
   logic tx_armed;

   logic ce_s;
   logic sclk_s;
   logic sdi_s;
   logic strap_s;
   logic ce_rise;
   logic active;
   logic sclk_rise;
   logic sclk_fall;
   logic sample_edge;
   logic launch_edge;
   logic byte_done;
   logic [7:0] next_rx;
   logic [1:0] ptr_after;
   logic load_rd;
   logic cfg_write;

   function automatic logic [1:0] next_ptr(input logic [1:0] p);
      return (p == `TSC_PTR_THI || p == `TSC_PTR_NONE) ? `TSC_PTR_CFG : p + 2'h1;
   endfunction : next_ptr

   function automatic logic [1:0] addr_to_ptr(input logic [7:0] a);
      return (a[`TSC_ADDR_PAD_HI:`TSC_ADDR_PAD_LO] == '0) ? a[`TSC_ADDR_PTR_HI:`TSC_ADDR_PTR_LO] : `TSC_PTR_NONE;
   endfunction : addr_to_ptr

   function automatic logic [7:0] rd_byte(input logic [1:0] p);
      logic [7:0] v;
      v = 8'h00;
      case (p)
         `TSC_PTR_CFG: v = {`TSC_CFG_FIXED, shot, res, sd};
         `TSC_PTR_TLO: v = temp_lo;
         `TSC_PTR_THI: v = temp_hi;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_byte

   function automatic logic [15:0] mask_sample(input logic [`TSC_ADC_BITS-1:0] s, input tsc_res_t r);
      logic [15:0] v;
      int unsigned bits;
      v = {s, {`TSC_PAD_BITS{1'b0}}};
      bits = r[`TSC_RES_TOP_BIT] ? `TSC_RES_MAX_BITS : `TSC_RES_MIN_BITS + 32'(r[1:0]);
      for (int unsigned i = 0; i < `TSC_TEMP_BITS; i++) begin
         if (i < `TSC_TEMP_BITS - bits) begin
            v[i] = 1'b0;
         end
      end
      return v;
   endfunction : mask_sample

   // pin synchronisers; only the second stage is read
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {i_interface_select_strap, i_serial_in, i_serial_clk, i_chip_enable};
         sync2 <= sync1;
      end
   end

   assign ce_s = sync2[0];
   assign sclk_s = sync2[1];
   assign sdi_s = sync2[2];
   assign strap_s = sync2[3];

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ce_q <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         ce_q <= ce_s;
         sclk_q <= sclk_s;
      end
   end

   assign ce_rise = ce_s && !ce_q;
   assign active = ce_s && ce_q;
   assign sclk_rise = sclk_s && !sclk_q;
   assign sclk_fall = !sclk_s && sclk_q;

   // mode and idle level frozen per frame so a mid-frame strap glitch cannot reorder bits
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         spi_mode <= 1'b1;
         idle_high <= 1'b0;
      end else if (ce_rise) begin
         spi_mode <= strap_s;
         idle_high <= sclk_s;
      end
   end

   // spi with phase one: leaving idle launches, returning to idle strobes
   assign sample_edge = active && (spi_mode ? (idle_high ? sclk_rise : sclk_fall) : sclk_rise);
   assign launch_edge = active && (spi_mode ? (idle_high ? sclk_fall : sclk_rise) : sclk_fall);
   assign next_rx = spi_mode ? {rx_sr[6:0], sdi_s} : {sdi_s, rx_sr[7:1]};
   assign byte_done = sample_edge && (bit_cnt == `TSC_BIT_LAST);
   assign ptr_after = (phase == ser_addr) ? addr_to_ptr(next_rx) : next_ptr(ptr);
   assign load_rd = byte_done && ((phase == ser_addr && !next_rx[`TSC_ADDR_DIR_BIT]) || phase == ser_read);
   assign cfg_write = byte_done && (phase == ser_write) && (ptr == `TSC_PTR_CFG);

   // frame state; the port never looks at shutdown
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase <= ser_addr;
         bit_cnt <= 3'h0;
         ptr <= `TSC_PTR_CFG;
         rx_sr <= 8'h00;
      end else if (!active) begin
         phase <= ser_addr;
         bit_cnt <= 3'h0;
         ptr <= `TSC_PTR_CFG;
         rx_sr <= 8'h00;
      end else if (sample_edge) begin
         rx_sr <= next_rx;
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_done) begin
            ptr <= ptr_after;
            if (phase == ser_addr) begin
               phase <= next_rx[`TSC_ADDR_DIR_BIT] ? ser_write : ser_read;
            end
         end
      end
   end

   // transmit shifter: a byte is loaded whole before the first bit leaves
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_sr <= 8'h00;
         tx_armed <= 1'b0;
      end else if (!active) begin
         tx_armed <= 1'b0;
      end else if (load_rd) begin
         tx_sr <= rd_byte(ptr_after);
         tx_armed <= 1'b1;
      end else if (launch_edge && tx_armed) begin
         tx_sr <= spi_mode ? {tx_sr[6:0], 1'b0} : {1'b0, tx_sr[7:1]};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_serial_out <= 1'b0;
         o_serial_out_oe_b <= 1'b1;
      end else if (!active || phase != ser_read || !tx_armed) begin
         o_serial_out_oe_b <= 1'b1;
      end else if (launch_edge) begin
         o_serial_out <= spi_mode ? tx_sr[7] : tx_sr[0];
         o_serial_out_oe_b <= 1'b0;
      end
   end

   // configuration register
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         res <= `TSC_RST_RES;
         sd <= `TSC_RST_SD;
      end else if (cfg_write) begin
         res <= next_rx[`TSC_CFG_RES_HI:`TSC_CFG_RES_LO];
         sd <= next_rx[`TSC_CFG_SD_BIT];
      end
   end

   // a new request beats the clear of the one just finished
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shot <= `TSC_RST_SHOT;
      end else if (cfg_write && sd && next_rx[`TSC_CFG_SHOT_BIT]) begin
         shot <= 1'b1;
      end else if (conv_link.done_shot) begin
         shot <= 1'b0;
      end
   end

   // temperature bytes take every finished result
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         temp_lo <= 8'h00;
         temp_hi <= 8'h00;
      end else if (conv_link.done) begin
         {temp_hi, temp_lo} <= mask_sample(i_adc_sample, conv_link.res_used);
      end
   end

   assign conv_link.shutdown = sd;
   assign conv_link.shot_req = shot;
   assign conv_link.res = res;

   tsc_conv_seq #(
      .CYC_8(CONV_CYC_8),
      .CYC_9(CONV_CYC_9),
      .CYC_10(CONV_CYC_10),
      .CYC_11(CONV_CYC_11),
      .CYC_12(CONV_CYC_12)
   ) u_conv (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .conv(conv_link.conv)
   );
endmodule : tsc_serial_config

// ### tsc_checker_assertions.sv
// port checker for the serial temperature front end
`timescale 1ns/100ps
module tsc_checker (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_chip_enable,
   input wire logic i_serial_clk,
   input wire logic i_serial_in,
   input wire logic i_interface_select_strap,
   input wire logic o_serial_out,
   input wire logic o_serial_out_oe_b
);
   logic sck_d, idle, spi, wr;
   logic [7:0] tc;
   logic [3:0] qc;
   wire tog = i_serial_clk != sck_d;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence ce_low5;
      (!i_chip_enable) [*5];
   endsequence
   sequence drv_chg;
      $changed(o_serial_out) && !o_serial_out_oe_b && i_chip_enable;
   endsequence
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sck_d <= 1'b0;
         qc <= 4'h0;
      end else begin
         sck_d <= i_serial_clk;
         qc <= tog ? 4'h0 : qc + {3'h0, qc != 4'hF};
      end
   end
   // idle level and mode follow the pins while disabled, so they hold the values seen at enable rise
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tc <= 8'h00;
         wr <= 1'b0;
         idle <= 1'b0;
         spi <= 1'b0;
      end else if (!i_chip_enable) begin
         tc <= 8'h00;
         wr <= 1'b0;
         idle <= i_serial_clk;
         spi <= i_interface_select_strap;
      end else if (tog) begin
         tc <= tc + {7'h00, tc != 8'hFF};
         if (tc == (spi ? 8'h01 : 8'h0E)) begin
            wr <= i_serial_in;
         end
      end
   end
   reset_idle_a: assert property ($rose(i_rst_b) |-> o_serial_out_oe_b && !o_serial_out)
      else $error("output active after reset");
   ce_release_a: assert property (ce_low5 |-> o_serial_out_oe_b)
      else $error("output driven while disabled");
   drive_hold_a: assert property (!o_serial_out_oe_b && i_chip_enable |=> !o_serial_out_oe_b)
      else $error("output released inside frame");
   drive_start_a: assert property ($fell(o_serial_out_oe_b) |-> i_chip_enable && tc >= 8'h10)
      else $error("output driven before address");
   write_quiet_a: assert property (wr |-> o_serial_out_oe_b)
      else $error("output driven in write");
   read_drive_a: assert property (i_chip_enable && !wr && tc == 8'h14 |-> !o_serial_out_oe_b)
      else $error("read data not driven");
   launch_edge_a: assert property (drv_chg |-> (spi ? i_serial_clk != idle : !i_serial_clk))
      else $error("output moved on wrong edge");
   launch_time_a: assert property (drv_chg |-> qc inside {[1:5]})
      else $error("output moved off launch time");
endmodule : tsc_checker
bind tsc_serial_config tsc_checker u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_chip_enable(i_chip_enable),
   .i_serial_clk(i_serial_clk), .i_serial_in(i_serial_in), .i_interface_select_strap(i_interface_select_strap),
   .o_serial_out(o_serial_out), .o_serial_out_oe_b(o_serial_out_oe_b));

// ### tsc_master.sv
// serial master model: spi and 3-wire frames with burst data
`timescale 1ns/100ps
module tsc_master (
   input wire logic i_clk,
   input wire logic i_serial_out,
   input wire logic i_serial_out_oe_b,
   output logic o_chip_enable,
   output logic o_serial_clk,
   output logic o_line
);
   logic md, drv, men;
   // shared line is pulled up; in spi a released input toggles so stale bits never read back
   assign o_line = md ? drv : (!i_serial_out_oe_b ? i_serial_out : (men ? drv : 1'b1));
   initial begin
      o_chip_enable = 1'b0;
      o_serial_clk = 1'b0;
      md = 1'b1;
      drv = 1'b0;
      men = 1'b0;
   end
   task automatic frame(input logic spi, input logic cpol, input logic [7:0] addr, input int n,
         input logic [31:0] wd, output logic [31:0] rd);
      logic [39:0] sh;
      int b;
      sh = {wd, addr};
      rd = 32'h0;
      md = spi;
      o_serial_clk = cpol;
      repeat (8) @(negedge i_clk);
      o_chip_enable = 1'b1;
      for (int i = 0; i < 8 * n + 8; i++) begin
         b = i / 8 * 8 + (spi ? 7 - i % 8 : i % 8);
         men = i < 8 || addr[7];
         if (!spi && men) drv = sh[b];
         repeat (8) @(negedge i_clk);
         o_serial_clk = ~o_serial_clk;
         if (spi) drv = men ? sh[b] : ~drv;
         if (!spi && i > 7) rd[b - 8] = o_line;
         repeat (8) @(negedge i_clk);
         o_serial_clk = ~o_serial_clk;
         if (spi && i > 7) rd[b - 8] = i_serial_out;
      end
      repeat (8) @(negedge i_clk);
      o_chip_enable = 1'b0;
      men = 1'b0;
      drv = ~drv;
      repeat (8) @(negedge i_clk);
   endtask : frame
endmodule : tsc_master

// ### tb.sv
// testbench: register access, one-shot and continuous conversions
`timescale 1ns/100ps
module tb;
   logic clk, rst_b, strap, ce, sclk, line, sout, oe_b;
   logic [11:0] adc, smp;
   logic [31:0] rd;
   int errors, n_compared;
   int seed = 32'h8F4D;
   tsc_serial_config #(.CONV_CYC_8(600), .CONV_CYC_9(700), .CONV_CYC_10(800), .CONV_CYC_11(900),
      .CONV_CYC_12(1000)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_chip_enable(ce), .i_serial_clk(sclk),
      .i_serial_in(line), .i_interface_select_strap(strap), .i_adc_sample(adc), .o_serial_out(sout),
      .o_serial_out_oe_b(oe_b));
   tsc_master mst (.i_clk(clk), .i_serial_out(sout), .i_serial_out_oe_b(oe_b), .o_chip_enable(ce),
      .o_serial_clk(sclk), .o_line(line));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [15:0] exp_t(input logic [2:0] r, input logic [11:0] s);
      int bits;
      bits = r[2] ? 12 : 8 + r[1:0];
      return {s, 4'h0} & (16'hFFFF << (16 - bits));
   endfunction : exp_t
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t read %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic s, input logic c, input logic [7:0] a, input int n, input logic [31:0] w);
      strap = s;
      mst.frame(s, c, a, n, w, rd);
   endtask : xfer
   task automatic final_report;
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      final_report();
   end
   initial begin
      rst_b = 1'b0;
      strap = 1'b1;
      adc = 12'h000;
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      xfer(1'b1, 1'b0, 8'h00, 4, 32'h0);
      chk(rd, 32'hE30000E3);
      // every resolution code, modes alternating
      for (int k = 0; k < 8; k++) begin
         smp = 12'($random(seed));
         adc = smp;
         xfer(k[0], k[1] & k[0], 8'h80, 1, {24'h0, 4'h1, k[2:0], 1'b1});
         xfer(k[0], 1'b0, 8'h00, 1, 32'h0);
         chk(rd, {24'h0, 4'hF, k[2:0], 1'b1});
         repeat (1100) @(negedge clk);
         adc = ~smp;
         repeat (1100) @(negedge clk);
         xfer(~k[0], 1'b0, 8'h00, 3, 32'h0);
         chk(rd, {8'h00, exp_t(k[2:0], smp), 4'hE, k[2:0], 1'b1});
      end
      xfer(1'b0, 1'b0, 8'h81, 3, 32'h000B55AA);
      xfer(1'b0, 1'b0, 8'h00, 3, 32'h0);
      chk(rd, {8'h00, exp_t(3'h7, smp), 8'hEB});
      smp = 12'($random(seed));
      adc = smp;
      xfer(1'b1, 1'b1, 8'h80, 1, 32'h00);
      xfer(1'b1, 1'b1, 8'h80, 1, 32'h10);
      repeat (1400) @(negedge clk);
      xfer(1'b1, 1'b1, 8'h00, 3, 32'h0);
      chk(rd, {8'h00, exp_t(3'h0, smp), 8'hE0});
      adc = ~smp;
      repeat (1400) @(negedge clk);
      xfer(1'b0, 1'b0, 8'h00, 3, 32'h0);
      chk(rd, {8'h00, exp_t(3'h0, ~smp), 8'hE0});
      adc = smp ^ 12'h5A5;
      xfer(1'b1, 1'b0, 8'h80, 1, 32'h01);
      repeat (700) @(negedge clk);
      adc = smp;
      repeat (1400) @(negedge clk);
      xfer(1'b1, 1'b0, 8'h00, 3, 32'h0);
      chk(rd, {8'h00, exp_t(3'h0, smp ^ 12'h5A5), 8'hE1});
      final_report();
   end
endmodule : tb
